// [rtl/stp_pkg.sv]
// Package: constants and types for the transmit coding path
package stp_pkg;
    // ==========================================
    // Register map
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_FRST = 4'h8;
    // Control register fields
    localparam int C_BSER = 0;
    localparam int C_DBL = 1;
    localparam int C_BYP = 2;
    localparam int C_LOCKEN = 3;
    localparam int C_BW = 4;
    localparam int C_REFSEL = 6;
    localparam int C_LINE = 9;
    localparam int C_OUTLN = 12;
    localparam int C_OUTSRC = 15;
    localparam int C_DIV = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0018;
    // Status register fields
    localparam int S_LOCK = 0;
    localparam int S_EMPTY = 1;
    localparam int S_FULL = 2;
    localparam int S_RD = 3;
    localparam int S_LOST = 4;
    localparam int S_INIT = 5;
    // ==========================================
    // Reference source codes
    localparam logic [2:0] REF_ZERO = 3'h0;
    localparam logic [2:0] REF_ONE = 3'h1;
    localparam logic [2:0] REF_ADJ = 3'h2;
    localparam logic [2:0] REF_LINE = 3'h3;
    localparam logic [2:0] REF_GLOBAL = 3'h4;
    localparam int NUM_LINES = 5;
    // Loop bandwidth choices
    typedef enum logic [1:0] {STP_BW_LOW, STP_BW_MED, STP_BW_HIGH} stp_bw_e;
    // ==========================================
    // Data path sizes
    localparam int LANES = 4;
    localparam int SYM_W = 10;
    localparam int BYTE_W = 8;
    localparam int PMA_W = 2 * SYM_W;
    // Fabric word with per-symbol control and disparity override
    typedef struct packed {
        logic [LANES-1:0] forceDisp;
        logic [LANES-1:0] dispVal;
        logic [LANES-1:0] ctrl;
        logic [LANES*SYM_W-1:0] data;
    } stp_word_s;
endpackage

// [rtl/stp_tx_path.sv]
// Transmit coding path: clock select, phase FIFO, byte serializer, encoder
// Contract
// RULE1: Two reference inputs; PLL reference also from adjacent, inter-block lines, global.
// RULE2: Incoming choice among five inter-block lines or global; drive exactly one line.
// RULE3: Global clock used as reference must come from a dedicated input pin.
// RULE4: PLL gives bit clock and load clock; per-channel divider sets channel rate.
// RULE5: Optional lock flag high while PLL locked, low otherwise.
// RULE6: Loop bandwidth is a static low, medium or high setting.
// RULE7: Phase FIFO between fabric and PLL domains, never bypassed.
// RULE8: FIFO reset only after PLL lock; PLL must stay locked afterwards.
// RULE9: Throughput matches; byte serializer enables double width at half rate.
// RULE10: Byte serializer splits each word in two halves: 16/20/32/40 to 8/10/16/20.
// RULE11: Serializer bypassable; words then pass with no width change.
// RULE12: Fabric width 8/10 or 16/20 single, 16/20 or 32/40 double.
// RULE13: Coding-to-serializer width 8/10 single, 16/20 double.
// RULE14: Byte ordering only available with byte serialization enabled.
// RULE15: Single-width 8-bit encoder mode and double-width cascaded 16-bit mode.
// RULE16: Run length at most five; encoder bypassable for raw data.
// RULE17: Single width: byte plus control flag gives one 10-bit group.
// RULE18: Double width: two cascaded encoders give a 20-bit group.
// RULE19: Code groups follow standard 8B/10B tables and disparity rules.
// RULE20: Running disparity starts negative after reset.
// RULE21: Disparity override enable and value replace current running disparity.
// RULE22: Lower byte first; upper starts from lower's ending disparity.
// RULE23: Byte serializer sends low half first, then high half.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module stp_tx_path #(
    parameter int FIFO_DEPTH = 4,
    parameter int DIV_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [stp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Reference clock inputs
    input wire logic reference_clock_zero,
    input wire logic reference_clock_one,
    input wire logic adjacentRefClock,
    input wire logic [stp_pkg::NUM_LINES-1:0] inter_block_clock_lines,
    input wire logic globalClock,
    // Reference clock outputs
    output logic pllRefClock,
    output logic [stp_pkg::NUM_LINES-1:0] outLineDrive,
    output logic outRefClock,
    // Transmit PLL
    input wire logic pllLockIn,
    output logic pllLocked,
    output logic [1:0] pllBandwidth,
    // Fabric side
    input wire stp_pkg::stp_word_s txWord,
    input wire logic txValid,
    output logic txReady,
    // Serializer side
    output logic [stp_pkg::PMA_W-1:0] pmaData,
    output logic pmaValid,
    output logic wordLoad
);
    import stp_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int CNT_W = PTR_W + 1;

    // ==========================================
    // One 8B/10B symbol: returns {ending disparity, code with bit a at bit 0}
    function automatic logic [10:0] stpEnc(input logic [7:0] d, input logic k,
                                            input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic [9:0] c;
        logic [4:0] x;
        logic [2:0] y;
        logic rd6;
        logic rdo;
        logic k28;
        logic alt;
        x = d[4:0];
        y = d[7:5];
        k28 = k && (x == 5'd28);
        // 5b/6b, negative column, written abcdei
        unique case (x)
            5'd0: c6 = 6'b100111;
            5'd1: c6 = 6'b011101;
            5'd2: c6 = 6'b101101;
            5'd3: c6 = 6'b110001;
            5'd4: c6 = 6'b110101;
            5'd5: c6 = 6'b101001;
            5'd6: c6 = 6'b011001;
            5'd7: c6 = 6'b111000;
            5'd8: c6 = 6'b111001;
            5'd9: c6 = 6'b100101;
            5'd10: c6 = 6'b010101;
            5'd11: c6 = 6'b110100;
            5'd12: c6 = 6'b001101;
            5'd13: c6 = 6'b101100;
            5'd14: c6 = 6'b011100;
            5'd15: c6 = 6'b010111;
            5'd16: c6 = 6'b011011;
            5'd17: c6 = 6'b100011;
            5'd18: c6 = 6'b010011;
            5'd19: c6 = 6'b110010;
            5'd20: c6 = 6'b001011;
            5'd21: c6 = 6'b101010;
            5'd22: c6 = 6'b011010;
            5'd23: c6 = 6'b111010;
            5'd24: c6 = 6'b110011;
            5'd25: c6 = 6'b100110;
            5'd26: c6 = 6'b010110;
            5'd27: c6 = 6'b110110;
            5'd28: c6 = k ? 6'b001111 : 6'b001110;
            5'd29: c6 = 6'b101110;
            5'd30: c6 = 6'b011110;
            5'd31: c6 = 6'b101011;
        endcase
        // Positive disparity takes the complement of unbalanced codes and of 111000
        if (rd && (($countones(c6) != 3) || (c6 == 6'b111000))) begin // see RULE19
            c6 = ~c6;
        end
        if ($countones(c6) > 3) begin
            rd6 = 1'b1;
        end else if ($countones(c6) < 3) begin
            rd6 = 1'b0;
        end else begin
            rd6 = rd;
        end
        // 3b/4b, negative column, written fghj
        unique case (y)
            3'd0: c4 = 4'b1011;
            3'd1: c4 = 4'b1001;
            3'd2: c4 = 4'b0101;
            3'd3: c4 = 4'b1100;
            3'd4: c4 = 4'b1101;
            3'd5: c4 = 4'b1010;
            3'd6: c4 = 4'b0110;
            3'd7: c4 = 4'b1110;
        endcase
        // Alternate x.7 avoids a run of five
        alt = (y == 3'd7) && (k || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
              || (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14))); // see RULE16
        if (alt) begin
            c4 = 4'b0111;
        end
        if (k28 && ($countones(c4) == 2) && (c4 != 4'b1100)) begin
            c4 = rd6 ? c4 : ~c4;
        end else if (rd6 && (($countones(c4) != 2) || (c4 == 4'b1100))) begin
            c4 = ~c4;
        end
        if ($countones(c4) > 2) begin
            rdo = 1'b1;
        end else if ($countones(c4) < 2) begin
            rdo = 1'b0;
        end else begin
            rdo = rd6;
        end
        // Bit a goes first on the line, so it lands in bit 0
        c = {c4[0], c4[1], c4[2], c4[3], c6[0], c6[1], c6[2], c6[3], c6[4], c6[5]};
        return {rdo, c};
    endfunction

    // ==========================================
    // Control register
    logic [31:0] ctrl_ff;
    logic byteSer;
    logic dblWidth;
    logic encBypass;

    // Software control write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
        end else if (regWr && regAddr == REG_CTRL) begin
            ctrl_ff <= regWrData;
        end
    end

    assign byteSer = ctrl_ff[C_BSER]; // see RULE9
    assign dblWidth = ctrl_ff[C_DBL]; // see RULE15
    assign encBypass = ctrl_ff[C_BYP];

    // ==========================================
    // Reference clock selection and outgoing line
    logic refSel;
    logic [2:0] lineIdx;
    logic [2:0] outIdx;

    assign lineIdx = ctrl_ff[C_LINE +: 3];
    assign outIdx = ctrl_ff[C_OUTLN +: 3];

    // Pick the PLL reference source
    always_comb begin
        unique case (ctrl_ff[C_REFSEL +: 3])
            REF_ONE: refSel = reference_clock_one; // see RULE1
            REF_ADJ: refSel = adjacentRefClock;
            REF_LINE: refSel = (lineIdx < 3'(NUM_LINES)) ?
                inter_block_clock_lines[lineIdx] : globalClock; // see RULE2
            REF_GLOBAL: refSel = globalClock; // see RULE3
            default: refSel = reference_clock_zero;
        endcase
    end

    // Registered reference and exactly one driven line
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pllRefClock <= 1'b0;
            outLineDrive <= '0;
            outRefClock <= 1'b0;
        end else begin
            pllRefClock <= refSel;
            outLineDrive <= (outIdx < 3'(NUM_LINES)) ?
                NUM_LINES'(1 << outIdx) : NUM_LINES'(1); // see RULE2
            outRefClock <= ctrl_ff[C_OUTSRC] ? reference_clock_one : reference_clock_zero;
        end
    end

    // ==========================================
    // PLL lock flag, bandwidth and lock tracking
    logic fifoInit_ff;
    logic lockLost_ff;
    logic fifoRst;

    assign fifoRst = regWr && (regAddr == REG_FRST);

    // Lock flag only when enabled, bandwidth held static
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pllLocked <= 1'b0;
            pllBandwidth <= STP_BW_MED;
        end else begin
            pllLocked <= ctrl_ff[C_LOCKEN] && pllLockIn; // see RULE5
            pllBandwidth <= (ctrl_ff[C_BW +: 2] == 2'd3) ?
                STP_BW_HIGH : ctrl_ff[C_BW +: 2]; // see RULE6
        end
    end

    // Lock lost after pointer init is sticky; a new loss beats the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifoInit_ff <= 1'b0;
            lockLost_ff <= 1'b0;
        end else begin
            if (fifoRst) begin
                fifoInit_ff <= pllLockIn; // see RULE8
            end
            if (fifoInit_ff && !pllLockIn) begin
                lockLost_ff <= 1'b1;
            end else if (fifoRst) begin
                lockLost_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Per-channel divider paces parallel loads
    logic [DIV_W-1:0] divCnt_ff;
    logic tick;

    assign tick = (divCnt_ff == ctrl_ff[C_DIV +: DIV_W]);

    // Load strobe every divide-plus-one cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCnt_ff <= '0;
            wordLoad <= 1'b0;
        end else begin
            divCnt_ff <= tick ? '0 : divCnt_ff + 1'b1; // see RULE4
            wordLoad <= tick;
        end
    end

    // ==========================================
    // Phase-compensation FIFO, always in the path
    stp_word_s mem_ff [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_ff;
    logic [PTR_W-1:0] rdPtr_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic bsHigh_ff;
    logic wrEn;
    logic rdEn;

    assign wrEn = txValid && txReady;
    assign rdEn = tick && (cnt_ff != '0) && !(byteSer && bsHigh_ff); // see RULE7
    assign nxt_cnt = cnt_ff + CNT_W'(wrEn) - CNT_W'(rdEn);

    // Pointers, fill count and ready
    always_ff @(posedge clk) begin
        if (!rst_n || fifoRst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            cnt_ff <= '0;
            txReady <= 1'b0;
        end else begin
            if (wrEn) begin
                wrPtr_ff <= (wrPtr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (rdEn) begin
                rdPtr_ff <= (rdPtr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            txReady <= nxt_cnt < CNT_W'(FIFO_DEPTH);
        end
    end

    // Storage, written by index
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem_ff[wrPtr_ff] <= txWord;
        end
    end

    // ==========================================
    // Byte serializer: low half first, high half next load
    typedef enum logic {STP_BS_LOW, STP_BS_HIGH} stp_bs_e;
    stp_bs_e bsState_ff;
    stp_word_s held_ff;

    assign bsHigh_ff = (bsState_ff == STP_BS_HIGH);

    // Half sequencing
    always_ff @(posedge clk) begin
        if (!rst_n || fifoRst) begin
            bsState_ff <= STP_BS_LOW;
            held_ff <= '0;
        end else if (tick) begin
            unique case (bsState_ff)
                STP_BS_LOW: begin
                    if (rdEn && byteSer) begin // see RULE14
                        held_ff <= mem_ff[rdPtr_ff];
                        bsState_ff <= STP_BS_HIGH; // see RULE23
                    end
                end
                STP_BS_HIGH: begin
                    bsState_ff <= STP_BS_LOW; // see RULE10
                end
            endcase
        end
    end

    // ==========================================
    // Lane pick and cascaded encoding
    logic rd_ff;
    stp_word_s srcWord;
    logic sendNow;
    int base;
    logic [PMA_W-1:0] nxt_pma;
    logic nxt_rd;

    assign sendNow = rdEn || (tick && byteSer && bsHigh_ff);
    assign srcWord = bsHigh_ff ? held_ff : mem_ff[rdPtr_ff];

    // Build one output word of one or two symbols
    always_comb begin
        logic [10:0] enc;
        logic rdCur;
        int ln;
        enc = '0;
        nxt_pma = '0;
        rdCur = rd_ff;
        ln = 0;
        // High half starts past the lanes of one output word
        base = (byteSer && bsHigh_ff) ? (dblWidth ? 2 : 1) : 0; // see RULE11
        for (int j = 0; j < 2; j++) begin
            ln = base + j;
            if (j == 0 || dblWidth) begin // see RULE13
                if (encBypass) begin
                    nxt_pma[j*SYM_W +: SYM_W] = srcWord.data[ln*SYM_W +: SYM_W]; // see RULE16
                end else begin
                    if (srcWord.forceDisp[ln]) begin
                        rdCur = srcWord.dispVal[ln]; // see RULE21
                    end
                    enc = stpEnc(srcWord.data[ln*BYTE_W +: BYTE_W],
                                 srcWord.ctrl[ln], rdCur); // see RULE17
                    nxt_pma[j*SYM_W +: SYM_W] = enc[SYM_W-1:0]; // see RULE18
                    rdCur = enc[SYM_W]; // see RULE22
                end
            end
        end
        nxt_rd = rdCur;
    end

    // Output register and running disparity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ff <= 1'b0; // see RULE20
            pmaData <= '0;
            pmaValid <= 1'b0;
        end else begin
            pmaValid <= sendNow;
            if (sendNow) begin
                pmaData <= nxt_pma; // see RULE12
                if (!encBypass) begin
                    rd_ff <= nxt_rd; // see RULE19
                end
            end
        end
    end

    // ==========================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                REG_CTRL: regRdData <= ctrl_ff;
                REG_STAT: regRdData <= {26'h000_0000, fifoInit_ff, lockLost_ff,
                    rd_ff, !txReady, cnt_ff == '0, pllLockIn};
                default: regRdData <= '0;
            endcase
        end else begin
            regRdData <= '0;
        end
    end

endmodule // stp_tx_path
`default_nettype wire

// [tb/stp_fabric_model.sv]
// Fabric model: queues transmit words and holds each until taken
`timescale 1ns/1ps
`default_nettype none
module stp_fabric_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Transmit handshake
    input wire logic txReady,
    output var stp_pkg::stp_word_s txWord,
    output var logic txValid
);
    import stp_pkg::*;
    // ==========================================
    // Words handed over by the bench
    stp_word_s pend[$];
    task automatic push(input stp_word_s w);
        pend.push_back(w);
    endtask
    // Idle at time zero
    initial begin
        txWord = '0;
        txValid = 1'b0;
    end
    // Word held until ready; idle data toggles every cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            txValid <= 1'b0;
        end else if (!txValid || txReady) begin
            if (pend.size() > 0) begin
                txWord <= pend.pop_front();
                txValid <= 1'b1;
            end else begin
                txValid <= 1'b0;
                txWord <= ~txWord;
            end
        end
    end
endmodule // stp_fabric_model
`default_nettype wire

// [tb/stp_path_chk_assertions.sv]
// Checker: port-level properties of the transmit coding path
`timescale 1ns/1ps
`default_nettype none
module stp_path_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [stp_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    // Reference clocks
    input wire logic reference_clock_zero,
    input wire logic reference_clock_one,
    input wire logic adjacentRefClock,
    input wire logic [stp_pkg::NUM_LINES-1:0] inter_block_clock_lines,
    input wire logic globalClock,
    input wire logic pllRefClock,
    input wire logic [stp_pkg::NUM_LINES-1:0] outLineDrive,
    input wire logic outRefClock,
    // PLL and data path
    input wire logic pllLockIn,
    input wire logic pllLocked,
    input wire logic [1:0] pllBandwidth,
    input wire logic txReady,
    input wire logic pmaValid,
    input wire logic wordLoad
);
    import stp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Pointer clear through the register port
    sequence fifo_clear_s;
        regWr && regAddr == REG_FRST;
    endsequence
    sequence ready_back_s;
        !txReady ##[1:3] txReady;
    endsequence
    // ==========================================
    // Properties
    rd_idle_zero_a: assert property (!regRd |=> regRdData == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    lock_flag_cause_a: assert property (pllLocked |-> $past(pllLockIn))
        else $error("lock flag high without lock input");
    bw_legal_a: assert property (pllBandwidth != 2'h3)
        else $error("loop bandwidth outside low, medium, high");
    line_onehot_a: assert property ($past(rst_n) |-> $onehot(outLineDrive))
        else $error("outgoing line drive not one-hot");
    out_ref_src_a: assert property (outRefClock |->
        $past(reference_clock_zero) || $past(reference_clock_one))
        else $error("outgoing reference high with both references low");
    pll_ref_src_a: assert property (pllRefClock |-> $past(reference_clock_zero) ||
        $past(reference_clock_one) || $past(adjacentRefClock) || $past(globalClock) ||
        $past(inter_block_clock_lines) != 5'h00)
        else $error("pll reference high with every source low");
    load_with_data_a: assert property (pmaValid |-> wordLoad)
        else $error("serializer word without load strobe");
    ready_release_a: assert property ($rose(rst_n) |-> ready_back_s)
        else $error("ready not raised shortly after reset");
    fifo_clear_a: assert property (fifo_clear_s |=> ready_back_s)
        else $error("pointer clear did not drop then restore ready");
endmodule // stp_path_chk
bind stp_tx_path stp_path_chk u_chk (.clk, .rst_n, .regAddr, .regWr, .regRd, .regRdData,
    .reference_clock_zero, .reference_clock_one, .adjacentRefClock,
    .inter_block_clock_lines, .globalClock, .pllRefClock, .outLineDrive, .outRefClock,
    .pllLockIn, .pllLocked, .pllBandwidth, .txReady, .pmaValid, .wordLoad);
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: registers, clock selection and coded transmit stream
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import stp_pkg::*;
    // ==========================================
    // Signals and bookkeeping
    logic clk, rst_n, regWr, regRd, refZero, refOne, adjRef, globalClock, pllLockIn;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic [NUM_LINES-1:0] lines, outLineDrive;
    logic pllRefClock, outRefClock, pllLocked, txValid, txReady, pmaValid, wordLoad;
    logic [1:0] pllBandwidth;
    logic [PMA_W-1:0] pmaData;
    stp_word_s txWord;
    logic [PMA_W-1:0] seenQ[$];
    logic [PMA_W-1:0] expQ[$];
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [9:0] kNeg = 10'h17C;
    localparam logic [9:0] kPos = 10'h283;
    localparam logic [9:0] dNeu = 10'h155;
    // ==========================================
    // Design and fabric partner
    stp_tx_path #(.FIFO_DEPTH(4), .DIV_W(4)) u_dut (.clk, .rst_n, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .reference_clock_zero(refZero),
        .reference_clock_one(refOne), .adjacentRefClock(adjRef),
        .inter_block_clock_lines(lines), .globalClock, .pllRefClock, .outLineDrive,
        .outRefClock, .pllLockIn, .pllLocked, .pllBandwidth, .txWord, .txValid, .txReady,
        .pmaData, .pmaValid, .wordLoad);
    stp_fabric_model u_fab (.clk, .rst_n, .txReady, .txWord, .txValid);
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Serializer words collected, and hang cut-off
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pmaValid === 1'b1) seenQ.push_back(pmaData);
        if (cycles == 20000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdData;
    endtask
    task automatic send(input logic [3:0] fd, dv, k, input logic [39:0] d, input logic [19:0] e);
        u_fab.push('{fd, dv, k, d});
        expQ.push_back(e);
    endtask
    task automatic drain;
        for (int i = 0; i < 300 && seenQ.size() < expQ.size(); i++) @(posedge clk);
        check(seenQ.size(), expQ.size(), "word count");
        while (expQ.size() > 0 && seenQ.size() > 0)
            check(seenQ.pop_front(), expQ.pop_front(), "symbol");
        expQ.delete();
    endtask
    task automatic report_and_stop;
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] d;
        rd(REG_CTRL, d);
        check(d, CTRL_RST, "control reset");
        rd(4'hC, d);
        check(d, 32'h0000_0000, "unmapped read");
        wr(REG_STAT, 32'hFFFF_FFFF);
        rd(REG_STAT, d);
        check({28'h0, d[3:0]}, 32'h0000_0003, "status after reset");
    endtask
    task automatic t_pll;
        for (int b = 0; b < 4; b++) begin
            wr(REG_CTRL, 32'h0000_0008 | (b << C_BW));
            repeat (2) @(posedge clk);
            check(pllBandwidth, (b == 3) ? 2 : b, "bandwidth");
        end
        wr(REG_CTRL, 32'h0000_0010);
        repeat (2) @(posedge clk);
        check(pllLocked, 1'b0, "lock flag off");
        wr(REG_CTRL, 32'h0000_0018);
        repeat (2) @(posedge clk);
        check(pllLocked, 1'b1, "lock flag on");
    endtask
    task automatic t_ref;
        for (int s = 0; s < 5; s++) begin
            wr(REG_CTRL, 32'h0000_3418 | (s << C_REFSEL));
            for (int v = 0; v < 2; v++) begin
                refZero <= (s == 0) ~^ v[0];
                refOne <= (s == 1) ~^ v[0];
                adjRef <= (s == 2) ~^ v[0];
                lines <= (s == 3) ? {2'b00 ~^ {2{v[0]}}, v[0], 2'b00 ~^ {2{v[0]}}} : {5{!v[0]}};
                globalClock <= (s == 4) ~^ v[0];
                repeat (3) @(posedge clk);
                check(pllRefClock, v[0], "reference select");
            end
        end
        wr(REG_CTRL, 32'h0000_B018);
        refOne <= 1'b1;
        refZero <= 1'b0;
        repeat (3) @(posedge clk);
        check({outRefClock, outLineDrive}, 6'b101000, "outgoing line 3");
        wr(REG_CTRL, 32'h0000_7018);
        repeat (3) @(posedge clk);
        check({outRefClock, outLineDrive}, 6'b000001, "outgoing line fold");
    endtask
    task automatic t_fifo;
        logic [31:0] d;
        wr(REG_FRST, 32'h0000_0000);
        rd(REG_STAT, d);
        check(d[5:4], 2'b10, "clear while locked");
        pllLockIn <= 1'b0;
        repeat (3) @(posedge clk);
        pllLockIn <= 1'b1;
        rd(REG_STAT, d);
        check(d[4], 1'b1, "lock loss sticky");
        wr(REG_FRST, 32'h0000_0000);
        rd(REG_STAT, d);
        check(d[5:4], 2'b10, "loss cleared");
    endtask
    task automatic t_code;
        wr(REG_CTRL, 32'h0000_0018);
        send(4'h0, 4'h0, 4'h1, 40'h00_0000_00BC, {10'h0, kNeg});
        send(4'h0, 4'h0, 4'h1, 40'h00_0000_00BC, {10'h0, kPos});
        send(4'h0, 4'h0, 4'h1, 40'h00_0000_00BC, {10'h0, kNeg});
        send(4'h0, 4'h0, 4'h0, 40'h00_0000_00B5, {10'h0, dNeu});
        drain();
        wr(REG_CTRL, 32'h0000_001A);
        send(4'h0, 4'h0, 4'h3, 40'h00_0000_BCBC, {kNeg, kPos});
        send(4'h1, 4'h0, 4'h3, 40'h00_0000_BCBC, {kPos, kNeg});
        drain();
        wr(REG_CTRL, 32'h0000_0019);
        send(4'h0, 4'h0, 4'h2, 40'h00_0000_BCB5, {10'h0, dNeu});
        expQ.push_back({10'h0, kNeg});
        drain();
        wr(REG_CTRL, 32'h0000_001B);
        send(4'h0, 4'h0, 4'hC, 40'h00_BCBC_B5B5, {dNeu, dNeu});
        expQ.push_back({kNeg, kPos});
        drain();
    endtask
    task automatic t_bypass;
        logic [19:0] r;
        wr(REG_CTRL, 32'h0003_001E);
        for (int i = 0; i < 6; i++) begin
            r = 20'hA_5C30 + i * 20'h0_1111;
            send(4'h0, 4'h0, 4'h0, {20'h0_0000, r}, r);
        end
        drain();
        wr(REG_CTRL, 32'h0000_001D);
        send(4'h0, 4'h0, 4'h0, 40'h00_000A_5C30, {10'h0, 10'h030});
        expQ.push_back({10'h0, 10'h297});
        drain();
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {rst_n, regWr, regRd, refOne, adjRef, globalClock} = '0;
        {refZero, pllLockIn} = 2'b11;
        regAddr = '0;
        regWrData = '0;
        lines = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_pll();
        t_ref();
        t_fifo();
        t_code();
        t_bypass();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
